// ### src/spfs_params.svh
`ifndef SPFS_PARAMS_SVH
`define SPFS_PARAMS_SVH

// register map, byte addresses on the 32-bit bus
`define SPFS_ADDR_W          4
`define SPFS_CTRL_OFFSET     4'h0
`define SPFS_STAT_OFFSET     4'h4

// control register layout
`define SPFS_CTRL_W          16
`define SPFS_CTRL_RESET      16'h0000
`define SPFS_CTRL_WMASK      16'h03FF
`define SPFS_FIELD_W         2
`define SPFS_NUM_PINS        5

// field encodings
`define SPFS_MODE_ALT        2'h0
`define SPFS_MODE_OUT        2'h1
`define SPFS_MODE_IN_PU      2'h2
`define SPFS_MODE_IN_NOPU    2'h3

// status register layout
`define SPFS_STAT_OE_LSB     8
`define SPFS_STAT_W          13

// serial channel pins
`define SPFS_CH0_PIN         0
`define SPFS_CH2_PIN         2
`define SPFS_RXD_IDLE        1'b1

`endif

// ### src/spfs_pkg.sv
`include "spfs_params.svh"

package spfs_pkg;

   typedef enum logic [1:0] {
      SPFS_ALT     = `SPFS_MODE_ALT,
      SPFS_OUT     = `SPFS_MODE_OUT,
      SPFS_IN_PU   = `SPFS_MODE_IN_PU,
      SPFS_IN_NOPU = `SPFS_MODE_IN_NOPU
   } spfs_mode_t;

   typedef enum logic [1:0] {
      SPFS_IDLE = 2'b01,
      SPFS_ACK  = 2'b10
   } spfs_state_t;

endpackage : spfs_pkg

// ### src/spfs_pin_cell.sv
`timescale 1ns/1ns
`include "spfs_params.svh"

module spfs_pin_cell #(
   parameter bit SERIAL = 1'b0
) (
   // mode and channel enables
   input  wire spfs_pkg::spfs_mode_t mode,
   input  wire logic                 tx_en,
   input  wire logic                 rx_en,
   // function sources
   input  wire logic                 port_out,
   input  wire logic                 ser_txd,
   input  wire logic                 alt_out,
   input  wire logic                 alt_oe,
   // pin levels
   input  wire logic                 tx_pin_in,
   input  wire logic                 rx_pin_in,
   // results
   output logic                      tx_out,
   output logic                      tx_oe,
   output logic                      pull_en,
   output logic                      port_in,
   output logic                      alt_in,
   output logic                      ser_rxd,
   output logic                      field_on
);

   logic tx_eff;
   logic rx_eff;
   logic in_pin;

   always_comb begin
      tx_eff   = SERIAL & tx_en;
      rx_eff   = SERIAL & rx_en;
      field_on = ~(tx_eff | rx_eff);
      // serial pins read port input on the receive pin, drive on transmit pin
      in_pin   = SERIAL ? rx_pin_in : tx_pin_in;
      tx_out   = alt_out;
      tx_oe    = 1'b0;
      pull_en  = 1'b0;
      port_in  = port_out;
      alt_in   = 1'b0;
      ser_rxd  = rx_eff ? rx_pin_in : `SPFS_RXD_IDLE;
      if (tx_eff) begin
         tx_out = ser_txd;
         tx_oe  = 1'b1;
      end
      if (field_on) begin
         case (mode)
            spfs_pkg::SPFS_ALT: begin
               tx_oe  = alt_oe;
               alt_in = in_pin;
            end
            spfs_pkg::SPFS_OUT: begin
               tx_out = port_out;
               tx_oe  = 1'b1;
            end
            spfs_pkg::SPFS_IN_PU: begin
               pull_en = 1'b1;
               port_in = in_pin;
            end
            default: begin
               port_in = in_pin;
            end
         endcase
      end
   end

endmodule : spfs_pin_cell

// ### src/spfs_top.sv
// Notes on behaviour
// - field 00 selects alternate function; 01 selects port output
// - field 10 is port input with pull-up; 11 input without pull-up
// - five read/write two-bit fields, pins 4..0, at bits 9:8 down to 1:0
// - pin 2 field applies only while channel 2 transmit and receive are off
// - channel 2 transmit enable makes pin 2 transmit pin carry serial data
// - channel 2 receive enable routes pin 2 receive pin to the channel
// - pin 2 port bit never inputs and outputs at once
// - pin 2 input mode: transmit pin driven only while transmit enabled
// - pin 0 field applies only while channel 0 transmit and receive are off
// - channel 0 transmit enable makes pin 0 transmit pin carry serial data
// - channel 0 receive enable routes pin 0 receive pin to the channel
// - pin 0 port bit never inputs and outputs at once
// - pin 0 input mode: transmit pin driven only while transmit enabled
// - bits 15 to 10 read zero; software writes only zero there
`timescale 1ns/1ns
`include "spfs_params.svh"

module spfs_top #(
   parameter int NPINS = `SPFS_NUM_PINS
) (
   // clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst,
   // avalon-mm slave
   input  wire logic [`SPFS_ADDR_W-1:0]    avs_address,
   input  wire logic                       avs_read,
   input  wire logic                       avs_write,
   input  wire logic [31:0]                avs_writedata,
   input  wire logic [3:0]                 avs_byteenable,
   output logic [31:0]                     avs_readdata,
   output logic                            avs_waitrequest,
   // serial channel 0
   input  wire logic                       ch0_transmit_enable,
   input  wire logic                       ch0_receive_enable,
   input  wire logic                       ch0_txd,
   output logic                            ch0_rxd,
   input  wire logic                       ch0_receive_pin_in,
   // serial channel 2
   input  wire logic                       ch2_transmit_enable,
   input  wire logic                       ch2_receive_enable,
   input  wire logic                       ch2_txd,
   output logic                            ch2_rxd,
   input  wire logic                       ch2_receive_pin_in,
   // other alternate functions
   input  wire logic [NPINS-1:0]           alt_out,
   input  wire logic [NPINS-1:0]           alt_oe,
   output logic [NPINS-1:0]                alt_in,
   // port data
   input  wire logic [NPINS-1:0]           port_out_data,
   output logic [NPINS-1:0]                port_in_data,
   // pins (transmit pin for 0 and 2)
   input  wire logic [NPINS-1:0]           pin_in,
   output logic [NPINS-1:0]                pin_out,
   output logic [NPINS-1:0]                pin_oe,
   output logic [NPINS-1:0]                pin_pullup
);

   spfs_pkg::spfs_state_t      state;
   spfs_pkg::spfs_state_t      next_state;
   logic [`SPFS_CTRL_W-1:0]    ctrl;
   logic [`SPFS_CTRL_W-1:0]    next_ctrl;
   logic [31:0]                next_readdata;
   logic                       next_waitrequest;
   logic [`SPFS_CTRL_W-1:0]    lane_mask;
   logic [`SPFS_STAT_W-1:0]    stat;

   spfs_pkg::spfs_mode_t       mode [NPINS];
   logic [NPINS-1:0]           tx_en_vec;
   logic [NPINS-1:0]           rx_en_vec;
   logic [NPINS-1:0]           txd_vec;
   logic [NPINS-1:0]           rx_pin_vec;
   logic [NPINS-1:0]           c_tx_out;
   logic [NPINS-1:0]           c_tx_oe;
   logic [NPINS-1:0]           c_pullup;
   logic [NPINS-1:0]           c_port_in;
   logic [NPINS-1:0]           c_alt_in;
   logic [NPINS-1:0]           c_ser_rxd;
   logic [NPINS-1:0]           c_field_on;
   logic [NPINS-1:0]           field_active;
   logic [NPINS-1:0]           next_field_active;
   logic [NPINS-1:0]           next_pin_out;
   logic [NPINS-1:0]           next_pin_oe;
   logic [NPINS-1:0]           next_pin_pullup;
   logic [NPINS-1:0]           next_port_in_data;
   logic [NPINS-1:0]           next_alt_in;
   logic                       next_ch0_rxd;
   logic                       next_ch2_rxd;

   // ---------------- register bus ----------------

   always_comb begin
      lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      stat      = '0;
      stat[NPINS-1:0] = field_active;
      stat[`SPFS_STAT_OE_LSB +: NPINS] = pin_oe;
   end

   always_comb begin
      next_state       = state;
      next_waitrequest = 1'b1;
      next_readdata    = avs_readdata;
      next_ctrl        = ctrl;
      case (state)
         spfs_pkg::SPFS_IDLE: begin
            if (avs_read || avs_write) begin
               next_state       = spfs_pkg::SPFS_ACK;
               next_waitrequest = 1'b0;
               if (avs_read) begin
                  case (avs_address)
                     `SPFS_CTRL_OFFSET: begin
                        next_readdata = {16'h0000, ctrl};
                     end
                     `SPFS_STAT_OFFSET: begin
                        next_readdata = {19'h0_0000, stat};
                     end
                     default: begin
                        next_readdata = 32'h0000_0000;
                     end
                  endcase
               end
            end
         end
         spfs_pkg::SPFS_ACK: begin
            next_state = spfs_pkg::SPFS_IDLE;
            // write lands on the edge where waitrequest is seen low
            if (avs_write && avs_address == `SPFS_CTRL_OFFSET) begin
               next_ctrl = (ctrl & ~(lane_mask & `SPFS_CTRL_WMASK))
                         | (avs_writedata[15:0] & lane_mask & `SPFS_CTRL_WMASK);
            end
         end
         default: begin
            next_state = spfs_pkg::SPFS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state           <= spfs_pkg::SPFS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         ctrl            <= `SPFS_CTRL_RESET;
      end else begin
         state           <= next_state;
         avs_waitrequest <= next_waitrequest;
         avs_readdata    <= next_readdata;
         ctrl            <= next_ctrl;
      end
   end

   // ---------------- pin function select ----------------

   always_comb begin
      tx_en_vec  = '0;
      rx_en_vec  = '0;
      txd_vec    = '0;
      rx_pin_vec = pin_in;
      tx_en_vec[`SPFS_CH0_PIN]  = ch0_transmit_enable;
      rx_en_vec[`SPFS_CH0_PIN]  = ch0_receive_enable;
      txd_vec[`SPFS_CH0_PIN]    = ch0_txd;
      rx_pin_vec[`SPFS_CH0_PIN] = ch0_receive_pin_in;
      tx_en_vec[`SPFS_CH2_PIN]  = ch2_transmit_enable;
      rx_en_vec[`SPFS_CH2_PIN]  = ch2_receive_enable;
      txd_vec[`SPFS_CH2_PIN]    = ch2_txd;
      rx_pin_vec[`SPFS_CH2_PIN] = ch2_receive_pin_in;
   end

   for (genvar i = 0; i < NPINS; i++) begin : g_pin
      assign mode[i] = spfs_pkg::spfs_mode_t'(ctrl[i*`SPFS_FIELD_W +: `SPFS_FIELD_W]);

      spfs_pin_cell #(
         .SERIAL (i == `SPFS_CH0_PIN || i == `SPFS_CH2_PIN)
      ) i_spfs_pin_cell (
         .mode      (mode[i]),
         .tx_en     (tx_en_vec[i]),
         .rx_en     (rx_en_vec[i]),
         .port_out  (port_out_data[i]),
         .ser_txd   (txd_vec[i]),
         .alt_out   (alt_out[i]),
         .alt_oe    (alt_oe[i]),
         .tx_pin_in (pin_in[i]),
         .rx_pin_in (rx_pin_vec[i]),
         .tx_out    (c_tx_out[i]),
         .tx_oe     (c_tx_oe[i]),
         .pull_en   (c_pullup[i]),
         .port_in   (c_port_in[i]),
         .alt_in    (c_alt_in[i]),
         .ser_rxd   (c_ser_rxd[i]),
         .field_on  (c_field_on[i])
      );
   end

   always_comb begin
      next_pin_out      = c_tx_out;
      next_pin_oe       = c_tx_oe;
      next_pin_pullup   = c_pullup;
      next_port_in_data = c_port_in;
      next_alt_in       = c_alt_in;
      next_field_active = c_field_on;
      next_ch0_rxd      = c_ser_rxd[`SPFS_CH0_PIN];
      next_ch2_rxd      = c_ser_rxd[`SPFS_CH2_PIN];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pin_out      <= '0;
         pin_oe       <= '0;
         pin_pullup   <= '0;
         port_in_data <= '0;
         alt_in       <= '0;
         field_active <= '1;
         ch0_rxd      <= `SPFS_RXD_IDLE;
         ch2_rxd      <= `SPFS_RXD_IDLE;
      end else begin
         pin_out      <= next_pin_out;
         pin_oe       <= next_pin_oe;
         pin_pullup   <= next_pin_pullup;
         port_in_data <= next_port_in_data;
         alt_in       <= next_alt_in;
         field_active <= next_field_active;
         ch0_rxd      <= next_ch0_rxd;
         ch2_rxd      <= next_ch2_rxd;
      end
   end

   // ---------------- checks ----------------

   a_reset_fields_alt: assert property (
      @(posedge clk) disable iff (rst)
      $past(rst) |-> (ctrl == `SPFS_CTRL_RESET && avs_waitrequest)
   ) else $error("fields not cleared after reset");

   a_reserved_read_zero: assert property (
      @(posedge clk) disable iff (rst)
      (state == spfs_pkg::SPFS_ACK && avs_read && avs_address == `SPFS_CTRL_OFFSET)
      |-> (avs_readdata[31:10] == 22'h00_0000 && !avs_waitrequest)
   ) else $error("reserved control bits read nonzero");

   a_field_write_lands: assert property (
      @(posedge clk) disable iff (rst)
      (state == spfs_pkg::SPFS_ACK && avs_write && avs_address == `SPFS_CTRL_OFFSET
       && avs_byteenable[1:0] == 2'b11)
      |=> ctrl == ($past(avs_writedata[15:0]) & `SPFS_CTRL_WMASK)
   ) else $error("control write not stored");

   a_ch0_port_out: assert property (
      @(posedge clk) disable iff (rst)
      (!ch0_transmit_enable && !ch0_receive_enable && mode[0] == spfs_pkg::SPFS_OUT)
      |=> (pin_oe[0] && pin_out[0] == $past(port_out_data[0]))
   ) else $error("pin 0 port output not driven");

   a_pin1_pullup: assert property (
      @(posedge clk) disable iff (rst)
      (mode[1] == spfs_pkg::SPFS_IN_PU) |=> (pin_pullup[1] && !pin_oe[1])
      ##0 (port_in_data[1] == $past(pin_in[1]))
   ) else $error("pin 1 input with pull-up wrong");

   a_pin3_no_pullup: assert property (
      @(posedge clk) disable iff (rst)
      (mode[3] == spfs_pkg::SPFS_IN_NOPU) |=> (!pin_pullup[3] && !pin_oe[3])
   ) else $error("pin 3 input without pull-up wrong");

   a_ch2_tx_override: assert property (
      @(posedge clk) disable iff (rst)
      ch2_transmit_enable |=> (pin_oe[2] && pin_out[2] == $past(ch2_txd) && !field_active[2])
   ) else $error("channel 2 transmit not on pin");

   a_ch0_tx_override: assert property (
      @(posedge clk) disable iff (rst)
      ch0_transmit_enable |=> (pin_oe[0] && pin_out[0] == $past(ch0_txd))
   ) else $error("channel 0 transmit not on pin");

   a_ch2_rx_route: assert property (
      @(posedge clk) disable iff (rst)
      ch2_receive_enable |=> (ch2_rxd == $past(ch2_receive_pin_in) && !pin_pullup[2])
   ) else $error("channel 2 receive not routed");

   a_ch0_rx_route: assert property (
      @(posedge clk) disable iff (rst)
      ch0_receive_enable |=> ch0_rxd == $past(ch0_receive_pin_in)
   ) else $error("channel 0 receive not routed");

   a_ch2_input_hiz: assert property (
      @(posedge clk) disable iff (rst)
      (mode[2][1] && !ch2_transmit_enable) |=> !pin_oe[2]
   ) else $error("pin 2 transmit pin driven in input mode");

   a_ch0_input_hiz: assert property (
      @(posedge clk) disable iff (rst)
      (mode[0][1] && !ch0_transmit_enable) |=> !pin_oe[0]
   ) else $error("pin 0 transmit pin driven in input mode");

   a_ch2_port_in: assert property (
      @(posedge clk) disable iff (rst)
      (!ch2_transmit_enable && !ch2_receive_enable && mode[2][1])
      |=> (port_in_data[2] == $past(ch2_receive_pin_in) && !pin_oe[2])
   ) else $error("pin 2 port input and output together");

   a_ch0_port_in: assert property (
      @(posedge clk) disable iff (rst)
      (!ch0_transmit_enable && !ch0_receive_enable && mode[0][1])
      |=> (port_in_data[0] == $past(ch0_receive_pin_in) && !pin_oe[0])
   ) else $error("pin 0 port input and output together");

   a_ch2_field_gate: assert property (
      @(posedge clk) disable iff (rst)
      (ch2_receive_enable && !ch2_transmit_enable && mode[2] == spfs_pkg::SPFS_OUT)
      |=> (!pin_oe[2] && !field_active[2])
   ) else $error("pin 2 field active with channel on");

   a_ch0_field_gate: assert property (
      @(posedge clk) disable iff (rst)
      (ch0_receive_enable && !ch0_transmit_enable && mode[0] == spfs_pkg::SPFS_OUT)
      |=> (!pin_oe[0] && !field_active[0])
   ) else $error("pin 0 field active with channel on");

   a_bus_one_wait: assert property (
      @(posedge clk) disable iff (rst)
      (state == spfs_pkg::SPFS_IDLE && (avs_read || avs_write))
      |=> !avs_waitrequest ##1 avs_waitrequest
   ) else $error("waitrequest not low for one cycle");

endmodule : spfs_top

// ### testbench/spfs_pin_model.sv
`timescale 1ns/1ns

module spfs_pin_model (
   // clock
   input  wire logic       clk,
   // pin drive from the block
   input  wire logic [4:0] pin_out,
   input  wire logic [4:0] pin_oe,
   input  wire logic [4:0] pin_pullup,
   // far side drivers
   input  wire logic [4:0] ext_en,
   input  wire logic [4:0] ext_val,
   // resolved levels
   output logic [4:0]      pin_in,
   output logic            ch0_rx_pin,
   output logic            ch2_rx_pin
);
   logic       tog = 1'b0;
   logic [4:0] rx_lvl;

   // undriven line without pull-up never holds a level
   always @(posedge clk) begin
      tog <= ~tog;
   end

   always_comb begin
      for (int i = 0; i < 5; i++) begin
         rx_lvl[i] = ext_en[i] ? ext_val[i] : (pin_pullup[i] ? 1'b1 : tog);
         pin_in[i] = pin_oe[i] ? pin_out[i] : rx_lvl[i];
      end
      // pins 0 and 2: transmit pin floats when not driven
      pin_in[0] = pin_oe[0] ? pin_out[0] : tog;
      pin_in[2] = pin_oe[2] ? pin_out[2] : tog;
      ch0_rx_pin = rx_lvl[0];
      ch2_rx_pin = rx_lvl[2];
   end
endmodule : spfs_pin_model

// ### testbench/spfs_top_tb_top.sv
`timescale 1ns/1ns
`include "spfs_params.svh"

module spfs_top_tb_top;
   logic                    clk = 1'b0;
   logic                    rst = 1'b1;
   logic [`SPFS_ADDR_W-1:0] avs_address = '0;
   logic                    avs_read = 1'b0;
   logic                    avs_write = 1'b0;
   logic [31:0]             avs_writedata = '0;
   logic [3:0]              avs_byteenable = 4'h3;
   logic [31:0]             avs_readdata;
   logic                    avs_waitrequest;
   logic [1:0]              tx_en = '0;
   logic [1:0]              rx_en = '0;
   logic [1:0]              txd = '0;
   logic [1:0]              rxd;
   logic                    ch0_rx_pin;
   logic                    ch2_rx_pin;
   logic [4:0]              alt_out = 5'h0a;
   logic [4:0]              alt_oe = 5'h1f;
   logic [4:0]              alt_in;
   logic [4:0]              port_out_data = 5'h15;
   logic [4:0]              port_in_data;
   logic [4:0]              pin_in;
   logic [4:0]              pin_out;
   logic [4:0]              pin_oe;
   logic [4:0]              pin_pullup;
   logic [4:0]              ext_en = '0;
   logic [4:0]              ext_val = '0;
   int                      error_cnt = 0;
   int                      n_tests = 0;

   always #4 clk = ~clk;

   spfs_top i_spfs_top (
      .clk(clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ch0_transmit_enable(tx_en[0]), .ch0_receive_enable(rx_en[0]), .ch0_txd(txd[0]),
      .ch0_rxd(rxd[0]), .ch0_receive_pin_in(ch0_rx_pin),
      .ch2_transmit_enable(tx_en[1]), .ch2_receive_enable(rx_en[1]), .ch2_txd(txd[1]),
      .ch2_rxd(rxd[1]), .ch2_receive_pin_in(ch2_rx_pin),
      .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
      .port_out_data(port_out_data), .port_in_data(port_in_data),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup)
   );

   spfs_pin_model i_spfs_pin_model (
      .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in),
      .ch0_rx_pin(ch0_rx_pin), .ch2_rx_pin(ch2_rx_pin)
   );

   task automatic complete_run();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // hold request until waitrequest seen low at a rising edge
   task automatic bus_wait(output logic [31:0] rd);
      int n;
      n = 0;
      rd = '0;
      // read right at the edge: values from before this edge's updates
      forever begin
         @(posedge clk);
         if (avs_waitrequest === 1'b0) break;
         n++;
         if (n > 20) begin
            check("waitrequest", 32'h0000_0000, 32'h0000_0001);
            break;
         end
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus_wait

   task automatic bus_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] rd;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      bus_wait(rd);
   endtask : bus_write

   task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_read <= 1'b1;
      bus_wait(d);
   endtask : bus_read

   // pin outputs lag their causes by one clock
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask : settle

   task automatic test_reset();
      logic [31:0] d;
      #1;
      check("pin_oe", 32'h0, pin_oe);
      check("pin_pullup", 32'h0, pin_pullup);
      check("rxd idle", 32'h3, rxd);
      @(posedge clk);
      rst <= 1'b0;
      bus_read(`SPFS_CTRL_OFFSET, d);
      check("ctrl reset", 32'h0000_0000, d);
      // fields at alternate function: oe follows alt_oe
      bus_read(`SPFS_STAT_OFFSET, d);
      check("status reset", 32'h0000_1f1f, d);
   endtask : test_reset

   task automatic test_regs();
      logic [31:0] d;
      bus_write(`SPFS_CTRL_OFFSET, 32'h0000_0fff, 4'h3);
      bus_read(`SPFS_CTRL_OFFSET, d);
      check("ctrl fields", 32'h0000_03ff, d);
      bus_write(`SPFS_CTRL_OFFSET, 32'h0000_0000, 4'h1);
      bus_read(`SPFS_CTRL_OFFSET, d);
      check("ctrl low lane", 32'h0000_0300, d);
      bus_write(4'h8, 32'h0000_0001, 4'h3);
      bus_write(`SPFS_STAT_OFFSET, 32'h0000_0000, 4'h3);
      bus_read(`SPFS_CTRL_OFFSET, d);
      check("ctrl after stray", 32'h0000_0300, d);
      bus_read(4'h8, d);
      check("unmapped read", 32'h0000_0000, d);
   endtask : test_regs

   // all five fields set alike, channels off
   task automatic test_modes();
      logic [1:0] m;
      for (int k = 0; k < 4; k++) begin
         m = 2'(k);
         @(posedge clk);
         ext_en <= 5'h1f;
         ext_val <= 5'h0c;
         bus_write(`SPFS_CTRL_OFFSET, {22'h0, m, m, m, m, m}, 4'h3);
         settle();
         case (m)
            2'h0: begin
               check("alt oe", 32'h1f, pin_oe);
               check("alt out", 32'h0a, pin_out);
               check("alt in", 32'h0e, alt_in);
            end
            2'h1: begin
               check("port oe", 32'h1f, pin_oe);
               check("port out", 32'h15, pin_out);
               check("port read", 32'h15, port_in_data);
            end
            default: begin
               check("input oe", 32'h00, pin_oe);
               check("input read", 32'h0c, port_in_data);
               check("pullup", (m == 2'h2) ? 32'h1f : 32'h0, pin_pullup);
            end
         endcase
      end
   endtask : test_modes

   // c = 0 for channel 0 (pin 0), 1 for channel 2 (pin 2)
   task automatic test_chan(input int c);
      int p;
      p = 2 * c;
      @(posedge clk);
      ext_en <= '0;
      bus_write(`SPFS_CTRL_OFFSET, 32'h1 << (2 * p), 4'h3);
      @(posedge clk);
      tx_en[c] <= 1'b1;
      txd[c] <= 1'b1;
      settle();
      check("tx oe", 32'h1, pin_oe[p]);
      check("tx data 1", 32'h1, pin_out[p]);
      @(posedge clk);
      txd[c] <= 1'b0;
      settle();
      check("tx data 0", 32'h0, pin_out[p]);
      bus_write(`SPFS_CTRL_OFFSET, 32'h2 << (2 * p), 4'h3);
      settle();
      check("input te oe", 32'h1, pin_oe[p]);
      check("override pullup", 32'h0, pin_pullup[p]);
      @(posedge clk);
      tx_en[c] <= 1'b0;
      settle();
      check("input hiz", 32'h0, pin_oe[p]);
      check("field pullup", 32'h1, pin_pullup[p]);
      @(posedge clk);
      rx_en[c] <= 1'b1;
      ext_en[p] <= 1'b1;
      ext_val[p] <= 1'b0;
      settle();
      check("rx data 0", 32'h0, rxd[c]);
      check("rx pullup", 32'h0, pin_pullup[p]);
      check("rx port", 32'(port_out_data[p]), port_in_data[p]);
      @(posedge clk);
      ext_val[p] <= 1'b1;
      settle();
      check("rx data 1", 32'h1, rxd[c]);
      @(posedge clk);
      rx_en[c] <= 1'b0;
      ext_val[p] <= 1'b0;
      settle();
      check("rx idle", 32'h1, rxd[c]);
   endtask : test_chan

   initial begin
      repeat (19) @(posedge clk);
      test_reset();
      test_regs();
      test_modes();
      test_chan(0);
      test_chan(1);
      complete_run();
   end

   initial begin
      #(8 * 20000);
      error_cnt++;
      complete_run();
   end
endmodule : spfs_top_tb_top
